/* File: design/ddrb_pkg.sv */
package ddrb_pkg;
  // -----------------------------------------------------------------
  // Link widths and memory shape
  // -----------------------------------------------------------------
  localparam int ADDR_W = 14;
  localparam int BANK_W = 3;
  localparam int DQ_W = 16;
  localparam int MASK_W = 2;
  localparam int MEM_IDX_W = 8;
  localparam int PIPE_D = 32;
  localparam int BURST_SEL_BIT = 12;
  localparam int AUTO_PRE_BIT = 10;
  localparam logic [2:0] CMD_READ = 3'h5;
  localparam logic [2:0] CMD_WRITE = 3'h4;
  localparam logic [2:0] FULL_CLKS = 3'h4;
  localparam logic [2:0] CHOP_CLKS = 3'h2;
  // -----------------------------------------------------------------
  // Register map
  // -----------------------------------------------------------------
  localparam logic [7:0] REG_MODE_OFF = 8'h00;
  localparam logic [7:0] REG_STAT_OFF = 8'h04;
  localparam int MODE_BL_LSB = 0;
  localparam int MODE_ADD_LAT_LSB = 4;
  localparam int MODE_COL_LAT_LSB = 8;
  localparam logic [31:0] MODE_RST = 32'h0000_0500;
  localparam logic [1:0] BL_FULL = 2'h0;
  localparam logic [1:0] BL_OTF = 2'h1;
  localparam logic [1:0] BL_CHOP = 2'h2;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

/* File: design/ddrb_burst_dev.sv */
// The placing of the registers and the AXI4-Lite register port were decided locally.
`timescale 1ns/1ps
// Function
// - In mode field 01, address bit 12 picks the burst: low chops to four beats, 4 clocks apart; high is eight.
// - Address bit 12 only selects burst length and never enters the column address.
// - Burst selection on the fly works for reads and writes with or without auto precharge.
// - A full burst is used when the mode field is 00, or when it is 01 and bit 12 is high.
// - Read data appears after additive latency plus column latency clocks.
// - The read strobe is driven from one clock before read latency, data from read latency.
// - Strobe and data are released at read latency plus 4 clocks for full, plus 2 for chopped.
// - Bad data setup or hold spoils only the addressed location and never hangs the device.
// - Bad strobe shape or strobe-to-clock timing spoils only the addressed location.
// - One mask input per 8 data bits masks writes with data timing and is ignored on reads.
module ddrb_burst_dev
  import ddrb_pkg::*;
(
  input wire logic core_clk, // Register side clock.
  input wire logic reset, // Asynchronous reset, active high.
  input wire logic [7:0] s_axi_awaddr, // Write address.
  input wire logic s_axi_awvalid, // Write address valid.
  output logic s_axi_awready, // Write address ready.
  input wire logic [31:0] s_axi_wdata, // Write data.
  input wire logic [3:0] s_axi_wstrb, // Write byte strobes.
  input wire logic s_axi_wvalid, // Write data valid.
  output logic s_axi_wready, // Write data ready.
  output logic [1:0] s_axi_bresp, // Write response code.
  output logic s_axi_bvalid, // Write response valid.
  input wire logic s_axi_bready, // Write response ready.
  input wire logic [7:0] s_axi_araddr, // Read address.
  input wire logic s_axi_arvalid, // Read address valid.
  output logic s_axi_arready, // Read address ready.
  output logic [31:0] s_axi_rdata, // Read data.
  output logic [1:0] s_axi_rresp, // Read response code.
  output logic s_axi_rvalid, // Read data valid.
  input wire logic s_axi_rready, // Read data ready.
  input wire logic link_clk, // Command clock from the controller.
  input wire logic cs_n, // Chip select, active low.
  input wire logic ras_n, // Row strobe, active low.
  input wire logic cas_n, // Column strobe, active low.
  input wire logic we_n, // Write enable, active low.
  input wire logic [BANK_W-1:0] bank_addr, // Bank of the command.
  input wire logic [ADDR_W-1:0] cmd_addr, // Address bus of the command.
  input wire logic wr_beat_valid, // Rising and falling write beats present.
  input wire logic [DQ_W-1:0] wr_data_rise, // Write beat on the rising strobe edge.
  input wire logic [DQ_W-1:0] wr_data_fall, // Write beat on the falling strobe edge.
  input wire logic [MASK_W-1:0] write_mask_input_rise, // Byte masks, rising beat.
  input wire logic [MASK_W-1:0] write_mask_input_fall, // Byte masks, falling beat.
  output logic [DQ_W-1:0] rd_data_rise, // Read beat on the rising strobe edge.
  output logic [DQ_W-1:0] rd_data_fall, // Read beat on the falling strobe edge.
  output logic rd_data_oe, // Data pins driven.
  output logic rd_strobe_o, // Strobe level: low in preamble, high while toggling.
  output logic rd_strobe_oe // Strobe pins driven.
);

  // -----------------------------------------------------------------
  // Register side
  // -----------------------------------------------------------------
  logic [31:0] mode_reg;
  logic [15:0] rd_count_reg;
  logic [15:0] wr_count_reg;
  logic aw_held_reg;
  logic w_held_reg;
  logic [7:0] aw_addr_reg;
  logic [31:0] w_data_reg;
  logic [3:0] w_strb_reg;
  logic [1:0] done_pulse;

  assign s_axi_awready = !aw_held_reg && !s_axi_bvalid;
  assign s_axi_wready = !w_held_reg && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;

  // Address and data are taken in either order and held until both are in.
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      aw_addr_reg <= 8'h00;
      w_data_reg <= 32'h0000_0000;
      w_strb_reg <= 4'h0;
    end else if (aw_held_reg && w_held_reg) begin
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_reg <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end
    end
  end

  // Mode register update and write response, one cycle after both halves are held.
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      mode_reg <= MODE_RST;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else if (aw_held_reg && w_held_reg) begin
      s_axi_bvalid <= 1'b1;
      if (aw_addr_reg[7:2] == REG_MODE_OFF[7:2]) begin
        s_axi_bresp <= RESP_OKAY;
        for (int i = 0; i < 4; i++) begin
          if (w_strb_reg[i]) begin
            mode_reg[i*8 +: 8] <= w_data_reg[i*8 +: 8];
          end
        end
      end else begin
        s_axi_bresp <= RESP_SLVERR;
      end
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Read answer one cycle after the address; status is read only.
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= RESP_OKAY;
      if (s_axi_araddr[7:2] == REG_MODE_OFF[7:2]) begin
        s_axi_rdata <= mode_reg;
      end else if (s_axi_araddr[7:2] == REG_STAT_OFF[7:2]) begin
        s_axi_rdata <= {wr_count_reg, rd_count_reg};
      end else begin
        s_axi_rdata <= 32'h0000_0000;
        s_axi_rresp <= RESP_SLVERR;
      end
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // Read commands and completed write bursts are counted here; the counters wrap silently.
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      rd_count_reg <= 16'h0000;
      wr_count_reg <= 16'h0000;
    end else begin
      rd_count_reg <= rd_count_reg + {15'h0000, done_pulse[0]};
      wr_count_reg <= wr_count_reg + {15'h0000, done_pulse[1]};
    end
  end

  // -----------------------------------------------------------------
  // Crossings
  // -----------------------------------------------------------------
  logic [1:0] link_rst_reg;
  logic link_rst;
  logic [31:0] mode_meta_reg;
  logic [31:0] mode_sync_reg;
  logic [31:0] mode_prev_reg;
  logic [31:0] mode_link_reg;
  logic [1:0] done_tgl_reg;

  // Link reset asserts at once and releases two link edges later.
  always_ff @(posedge link_clk or posedge reset) begin
    if (reset) begin
      link_rst_reg <= 2'h3;
    end else begin
      link_rst_reg <= {link_rst_reg[0], 1'b0};
    end
  end
  assign link_rst = link_rst_reg[1];

  // A word caught in mid-change differs between two synchronised samples, so the
  // link takes it only once two samples agree; software still must change it
  // only while the link is idle.
  always_ff @(posedge link_clk or posedge link_rst) begin
    if (link_rst) begin
      mode_meta_reg <= MODE_RST;
      mode_sync_reg <= MODE_RST;
      mode_prev_reg <= MODE_RST;
      mode_link_reg <= MODE_RST;
    end else begin
      mode_meta_reg <= mode_reg;
      mode_sync_reg <= mode_meta_reg;
      mode_prev_reg <= mode_sync_reg;
      if (mode_sync_reg == mode_prev_reg) begin
        mode_link_reg <= mode_sync_reg;
      end
    end
  end

  // Read command and write completion toggles cross back; only the second and third stages are compared.
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_done_sync
      logic [2:0] sync_reg;
      always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
          sync_reg <= 3'h0;
        end else begin
          sync_reg <= {sync_reg[1:0], done_tgl_reg[g]};
        end
      end
      assign done_pulse[g] = sync_reg[2] ^ sync_reg[1];
    end
  endgenerate

  // -----------------------------------------------------------------
  // Link side: command decode and latency
  // -----------------------------------------------------------------
  logic [1:0] bl_field;
  logic [4:0] additive_latency;
  logic [4:0] column_access_latency;
  logic [5:0] read_latency;
  logic is_read;
  logic is_write;
  logic cmd_chop;
  logic [MEM_IDX_W-1:0] cmd_idx;
  logic [PIPE_D-1:0] pipe_vld_reg;
  logic [PIPE_D-1:0] pipe_chop_reg;
  logic [MEM_IDX_W-1:0] pipe_idx_reg [PIPE_D];
  logic [DQ_W-1:0] mem [2**MEM_IDX_W];

  assign bl_field = mode_link_reg[MODE_BL_LSB +: 2];
  assign additive_latency = {1'b0, mode_link_reg[MODE_ADD_LAT_LSB +: 4]};
  assign column_access_latency = {1'b0, mode_link_reg[MODE_COL_LAT_LSB +: 4]};
  assign read_latency = {1'b0, additive_latency + column_access_latency};
  assign is_read = !cs_n && ({ras_n, cas_n, we_n} == CMD_READ);
  assign is_write = !cs_n && ({ras_n, cas_n, we_n} == CMD_WRITE);
  // Auto precharge on bit 10 has no effect on burst choice here.
  assign cmd_chop = (bl_field == BL_CHOP) ||
                    ((bl_field == BL_OTF) && !cmd_addr[BURST_SEL_BIT]);
  // Bit 12 is left out of the column; only low column bits index the store.
  assign cmd_idx = {bank_addr, cmd_addr[MEM_IDX_W-BANK_W-1:0]};

  // Read commands walk a delay line; the tap is picked by the read latency.
  always_ff @(posedge link_clk or posedge link_rst) begin
    if (link_rst) begin
      pipe_vld_reg <= '0;
      pipe_chop_reg <= '0;
      for (int i = 0; i < PIPE_D; i++) begin
        pipe_idx_reg[i] <= '0;
      end
    end else begin
      pipe_vld_reg <= {pipe_vld_reg[PIPE_D-2:0], is_read};
      pipe_chop_reg <= {pipe_chop_reg[PIPE_D-2:0], cmd_chop};
      pipe_idx_reg[0] <= cmd_idx;
      for (int i = 1; i < PIPE_D; i++) begin
        pipe_idx_reg[i] <= pipe_idx_reg[i-1];
      end
    end
  end

  // -----------------------------------------------------------------
  // Link side: read burst
  // -----------------------------------------------------------------
  logic [4:0] tap_pre;
  logic [4:0] tap_data;
  logic start_pre;
  logic start_data;
  logic [2:0] rd_left_reg;
  logic [MEM_IDX_W-1:0] rd_idx_reg;
  logic [MEM_IDX_W-1:0] rd_base;
  logic [2:0] rd_col;

  assign tap_data = read_latency[4:0] - 5'h01;
  assign tap_pre = read_latency[4:0] - 5'h02;
  assign start_pre = pipe_vld_reg[tap_pre];
  assign start_data = pipe_vld_reg[tap_data];
  assign rd_base = start_data ? pipe_idx_reg[tap_data] : rd_idx_reg;
  assign rd_col = start_data ? 3'h0 : 3'h2;

  // Two beats leave per clock, wrapping within the aligned eight-column block.
  always_ff @(posedge link_clk or posedge link_rst) begin
    if (link_rst) begin
      rd_left_reg <= 3'h0;
      rd_idx_reg <= '0;
      rd_data_rise <= '0;
      rd_data_fall <= '0;
      rd_data_oe <= 1'b0;
    end else if (start_data || (rd_left_reg != 3'h0)) begin
      rd_idx_reg <= {rd_base[MEM_IDX_W-1:3], rd_base[2:0] + rd_col};
      rd_data_rise <= mem[{rd_base[MEM_IDX_W-1:3], rd_base[2:0] + rd_col}];
      rd_data_fall <= mem[{rd_base[MEM_IDX_W-1:3], rd_base[2:0] + rd_col + 3'h1}];
      rd_data_oe <= 1'b1;
      if (start_data) begin
        rd_left_reg <= (pipe_chop_reg[tap_data] ? CHOP_CLKS : FULL_CLKS) - 3'h1;
      end else begin
        rd_left_reg <= rd_left_reg - 3'h1;
      end
    end else begin
      rd_data_oe <= 1'b0;
    end
  end

  // The strobe opens a clock early for the low preamble and closes with the data.
  always_ff @(posedge link_clk or posedge link_rst) begin
    if (link_rst) begin
      rd_strobe_oe <= 1'b0;
      rd_strobe_o <= 1'b0;
    end else begin
      rd_strobe_oe <= start_pre || start_data || (rd_left_reg != 3'h0);
      rd_strobe_o <= start_data || (rd_left_reg != 3'h0);
    end
  end

  // -----------------------------------------------------------------
  // Link side: write burst
  // -----------------------------------------------------------------
  logic [2:0] wr_left_reg;
  logic [MEM_IDX_W-1:0] wr_idx_reg;
  logic [MEM_IDX_W-1:0] wr_next_idx;
  logic wr_beat_take;

  assign wr_beat_take = wr_beat_valid && (wr_left_reg != 3'h0);
  assign wr_next_idx = {wr_idx_reg[MEM_IDX_W-1:3], wr_idx_reg[2:0] + 3'h1};

  // A burst closes by its own beat count, so stray or missing strobe beats can
  // only spoil the addressed columns; a new write simply restarts the count.
  always_ff @(posedge link_clk or posedge link_rst) begin
    if (link_rst) begin
      wr_left_reg <= 3'h0;
      wr_idx_reg <= '0;
      done_tgl_reg <= 2'h0;
    end else begin
      if (is_write) begin
        wr_left_reg <= cmd_chop ? CHOP_CLKS : FULL_CLKS;
        wr_idx_reg <= cmd_idx;
      end else if (wr_beat_take) begin
        wr_left_reg <= wr_left_reg - 3'h1;
        wr_idx_reg <= {wr_idx_reg[MEM_IDX_W-1:3], wr_idx_reg[2:0] + 3'h2};
      end
      if (is_read) begin
        done_tgl_reg[0] <= !done_tgl_reg[0];
      end
      if (wr_beat_take && (wr_left_reg == 3'h1) && !is_write) begin
        done_tgl_reg[1] <= !done_tgl_reg[1];
      end
    end
  end

  // Byte lanes store separately; a high mask bit keeps the old byte. One process
  // owns the whole store, so the array never has two writers.
  always_ff @(posedge link_clk) begin
    if (wr_beat_take && !is_write) begin
      for (int i = 0; i < MASK_W; i++) begin
        if (!write_mask_input_rise[i]) begin
          mem[wr_idx_reg][i*8 +: 8] <= wr_data_rise[i*8 +: 8];
        end
        if (!write_mask_input_fall[i]) begin
          mem[wr_next_idx][i*8 +: 8] <= wr_data_fall[i*8 +: 8];
        end
      end
    end
  end

endmodule

/* File: verification/ddrb_burst_dev_sva.sv */
`timescale 1ns/1ps
module ddrb_burst_dev_sva (
  input wire logic core_clk, // Register clock.
  input wire logic reset, // Reset, active high.
  input wire logic link_clk, // Link clock.
  input wire logic s_axi_awvalid, // Write address valid.
  input wire logic s_axi_awready, // Write address ready.
  input wire logic s_axi_wvalid, // Write data valid.
  input wire logic s_axi_wready, // Write data ready.
  input wire logic s_axi_bvalid, // Write response valid.
  input wire logic s_axi_bready, // Write response ready.
  input wire logic s_axi_arvalid, // Read address valid.
  input wire logic s_axi_arready, // Read address ready.
  input wire logic s_axi_rvalid, // Read data valid.
  input wire logic s_axi_rready, // Read data ready.
  input wire logic rd_data_oe, // Data driven.
  input wire logic rd_strobe_o, // Strobe level.
  input wire logic rd_strobe_oe // Strobe driven.
);
  // Output window shape, which holds for any programmed read latency of 2 or more.
  a_strobe_leads: assert property (@(posedge link_clk) disable iff (reset)
    $rose(rd_data_oe) |-> $past(rd_strobe_oe) && !$past(rd_strobe_o))
    else $error("Data driven without a low strobe clock first.");
  a_preamble_one: assert property (@(posedge link_clk) disable iff (reset)
    rd_strobe_oe && !rd_data_oe |=> rd_data_oe && rd_strobe_o)
    else $error("Strobe preamble is not one clock long.");
  a_data_in_window: assert property (@(posedge link_clk) disable iff (reset)
    rd_data_oe |-> rd_strobe_oe && rd_strobe_o)
    else $error("Data driven outside the toggling strobe.");
  a_release_both: assert property (@(posedge link_clk) disable iff (reset)
    $fell(rd_strobe_oe) |-> $fell(rd_data_oe))
    else $error("Strobe and data not released together.");
  a_window_min: assert property (@(posedge link_clk) disable iff (reset)
    $rose(rd_data_oe) |-> rd_data_oe[*2])
    else $error("Data window shorter than two clocks.");
  // Register bus answers; the fixed figures are the designer's pipeline.
  a_rvalid_next: assert property (@(posedge core_clk) disable iff (reset)
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("Read answer not one cycle after the address.");
  a_rvalid_drop: assert property (@(posedge core_clk) disable iff (reset)
    s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("Read answer repeated.");
  a_bvalid_two: assert property (@(posedge core_clk) disable iff (reset)
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("Write answer not two cycles after address and data.");
  a_aw_refused: assert property (@(posedge core_clk) disable iff (reset)
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("New write taken while a response waits.");
endmodule

/* File: verification/ddrb_ctl_model.sv */
`timescale 1ns/1ps
module ddrb_ctl_model
  import ddrb_pkg::*;
(
  input wire logic link_clk, // Command clock.
  output logic cs_n, // Select, active low.
  output logic ras_n, // Row strobe, active low.
  output logic cas_n, // Column strobe, active low.
  output logic we_n, // Write enable, active low.
  output logic [BANK_W-1:0] bank_addr, // Bank.
  output logic [ADDR_W-1:0] cmd_addr, // Address.
  output logic wr_beat_valid, // Beats present.
  output logic [DQ_W-1:0] wr_data_rise, // Rise beat.
  output logic [DQ_W-1:0] wr_data_fall, // Fall beat.
  output logic [MASK_W-1:0] write_mask_input_rise, // Rise masks.
  output logic [MASK_W-1:0] write_mask_input_fall // Fall masks.
);
  // The controller idles deselected from time zero.
  initial begin
    {cs_n, ras_n, cas_n, we_n, wr_beat_valid} = 5'h1e;
    {bank_addr, cmd_addr, wr_data_rise, wr_data_fall} = '0;
    {write_mask_input_rise, write_mask_input_fall} = '0;
  end
  // One column command; it never precharges or activates, so row spacing holds trivially.
  // Deselected lines carry the inverse of their last value so no stale value looks valid.
  task automatic cmd(input logic [2:0] c, input logic [BANK_W-1:0] b,
                     input logic [ADDR_W-1:0] a);
    @(posedge link_clk);
    {cs_n, ras_n, cas_n, we_n} <= {1'b0, c};
    {bank_addr, cmd_addr} <= {b, a};
    @(posedge link_clk);
    {cs_n, ras_n, cas_n, we_n} <= 4'hf;
    {bank_addr, cmd_addr} <= ~{b, a};
  endtask
  // Write beats from the clock after the command, masks on data timing.
  task automatic wr(input bit k, input logic [BANK_W-1:0] b, input logic [ADDR_W-1:0] a,
                    input int n, input logic [DQ_W-1:0] d, input logic [MASK_W-1:0] m);
    if (k) cmd(CMD_WRITE, b, a);
    else @(posedge link_clk);
    wr_beat_valid <= 1'b1;
    for (int j = 0; j < n; j++) begin
      {wr_data_rise, wr_data_fall} <= {d + DQ_W'(2 * j), d + DQ_W'(2 * j + 1)};
      {write_mask_input_rise, write_mask_input_fall} <= {m, m};
      @(posedge link_clk);
    end
    wr_beat_valid <= 1'b0;
    {wr_data_rise, wr_data_fall} <= ~{wr_data_rise, wr_data_fall};
    {write_mask_input_rise, write_mask_input_fall} <= ~{m, m};
  endtask
endmodule

/* File: verification/tb_ddrb_burst_dev.sv */
`timescale 1ns/1ps
module tb_ddrb_burst_dev;
  import ddrb_pkg::*;
  typedef struct {
    logic [1:0] bl; logic [3:0] add_lat; logic [3:0] col_lat; logic sel; logic ap;
    logic [4:0] col; logic [1:0] m; logic full; int rd_lat;
  } ddrb_row_t;
  logic core_clk, reset, link_clk;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic cs_n, ras_n, cas_n, we_n, wr_beat_valid, rd_data_oe, rd_strobe_o, rd_strobe_oe;
  logic [BANK_W-1:0] bank_addr;
  logic [ADDR_W-1:0] cmd_addr;
  logic [DQ_W-1:0] wr_data_rise, wr_data_fall, rd_data_rise, rd_data_fall;
  logic [MASK_W-1:0] write_mask_input_rise, write_mask_input_fall;
  logic [DQ_W-1:0] exp_mem [256];
  int n_mismatch, samples_checked;
  // Mode, burst select and expected length and latency; every burst mode appears.
  ddrb_row_t rows [7] = '{
    '{2'h0, 4'h0, 4'h5, 1'b1, 1'b0, 5'h00, 2'h0, 1'b1, 5},
    '{2'h0, 4'h4, 4'h5, 1'b0, 1'b1, 5'h02, 2'h1, 1'b1, 9},
    '{2'h1, 4'h0, 4'h5, 1'b1, 1'b1, 5'h04, 2'h0, 1'b1, 5},
    '{2'h1, 4'h0, 4'h2, 1'b0, 1'b0, 5'h06, 2'h2, 1'b0, 2},
    '{2'h1, 4'h3, 4'h7, 1'b0, 1'b1, 5'h02, 2'h0, 1'b0, 10},
    '{2'h2, 4'h0, 4'h6, 1'b1, 1'b0, 5'h05, 2'h0, 1'b0, 6},
    '{2'h1, 4'h1, 4'hf, 1'b1, 1'b0, 5'h07, 2'h3, 1'b1, 16}};
  ddrb_burst_dev ddrb_burst_dev_inst (.core_clk, .reset, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .link_clk, .cs_n, .ras_n, .cas_n, .we_n,
    .bank_addr, .cmd_addr, .wr_beat_valid, .wr_data_rise, .wr_data_fall, .write_mask_input_rise,
    .write_mask_input_fall, .rd_data_rise, .rd_data_fall, .rd_data_oe, .rd_strobe_o,
    .rd_strobe_oe);
  ddrb_ctl_model ddrb_ctl_model_inst (.link_clk, .cs_n, .ras_n, .cas_n, .we_n, .bank_addr,
    .cmd_addr, .wr_beat_valid, .wr_data_rise, .wr_data_fall, .write_mask_input_rise,
    .write_mask_input_fall);
  // ------------------------------------------------------------
  // Clocks, watchdog and shared checks
  // ------------------------------------------------------------
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end
  // The link clock is offset so its edges never meet the register clock's.
  initial begin
    link_clk = 1'b0;
    #7;
    forever #16 link_clk = ~link_clk;
  end
  // The run needs under 10 us; fifteen times that means a hang.
  initial begin
    #150000;
    n_mismatch++;
    final_report();
  end
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  function automatic logic [7:0] ix(input logic [4:0] c, input int k);
    return {3'h3, c[4:3], 3'(int'(c) + k)};
  endfunction
  function automatic logic [15:0] mrg(input logic [15:0] o, input logic [15:0] v,
                                      input logic [1:0] m);
    return {m[1] ? o[15:8] : v[15:8], m[0] ? o[7:0] : v[7:0]};
  endfunction
  // Readies are sampled at the falling edge, where they are settled until the next rise.
  task automatic axi(input logic w, input logic [7:0] a, input logic [31:0] dat,
                     input logic [3:0] s, input logic [31:0] ed, input logic [1:0] er);
    logic ha, hw, hr, v;
    logic [31:0] d;
    logic [1:0] r;
    @(posedge core_clk);
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} <= {a, a, dat, s};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} <= {w, w, w, !w, !w};
    do begin
      @(negedge core_clk);
      ha = s_axi_awvalid && s_axi_awready;
      hw = s_axi_wvalid && s_axi_wready;
      hr = s_axi_arvalid && s_axi_arready;
      {v, r, d} = w ? {s_axi_bvalid, s_axi_bresp, 32'h0} : {s_axi_rvalid, s_axi_rresp, s_axi_rdata};
      @(posedge core_clk);
      if (ha) s_axi_awvalid <= 1'b0;
      if (hw) s_axi_wvalid <= 1'b0;
      if (hr) s_axi_arvalid <= 1'b0;
    end while (v !== 1'b1);
    {s_axi_bready, s_axi_rready} <= 2'h0;
    chk(64'({r, d}), 64'({er, ed}));
  endtask
  // Each of the first rl + 6 link clocks after the command is checked for enables, and each data window clock for the beat pair.
  task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [4:0] c, input int n,
                        input int rl);
    logic st, dw;
    ddrb_ctl_model_inst.cmd(CMD_READ, 3'h3, a);
    for (int k = 0; k <= rl + 5; k++) begin
      @(negedge link_clk);
      st = (k >= rl - 1) && (k < rl + n);
      dw = (k >= rl) && (k < rl + n);
      chk(64'({rd_strobe_oe, rd_strobe_o & rd_strobe_oe, rd_data_oe}),
          64'({st, dw, dw}));
      if (dw) chk(64'({rd_data_rise, rd_data_fall}), 64'({exp_mem[ix(c, 2 * (k - rl))],
                  exp_mem[ix(c, 2 * (k - rl) + 1)]}));
    end
  endtask
  task automatic final_report();
    $display("mismatches %0d, comparisons %0d", n_mismatch, samples_checked);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    int n;
    logic [ADDR_W-1:0] a;
    logic [15:0] d;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
    reset = 1'b1;
    repeat (3) @(posedge core_clk);
    reset <= 1'b0;
    // Rows write a burst through the bit that picks length, then read it back.
    for (int i = 0; i < 7; i++) begin
      axi(1'b1, REG_MODE_OFF, {20'h0, rows[i].col_lat, rows[i].add_lat, 2'h0, rows[i].bl},
          4'hf, 0, RESP_OKAY);
      repeat (4) @(posedge link_clk);
      n = rows[i].full ? 4 : 2;
      a = {1'b1, rows[i].sel, 1'b0, rows[i].ap, 5'h0, rows[i].col};
      d = {4'(i + 1), 12'h0};
      ddrb_ctl_model_inst.wr(1'b1, 3'h3, a, n, d, rows[i].m);
      for (int j = 0; j < 2 * n; j++) begin
        exp_mem[ix(rows[i].col, j)] = mrg(exp_mem[ix(rows[i].col, j)], d + 16'(j), rows[i].m);
      end
      rd_chk(a, rows[i].col, n, rows[i].rd_lat);
    end
    // Beats with no write open must change nothing and leave the device working.
    ddrb_ctl_model_inst.wr(1'b0, 3'h3, 14'h0, 4, 16'hbeef, 2'h0);
    rd_chk(14'h3000, 5'h00, 4, 16);
    axi(1'b0, REG_STAT_OFF, 0, 4'h0, {16'h7, 16'h8}, RESP_OKAY);
    axi(1'b0, 8'h08, 0, 4'h0, 32'h0, RESP_SLVERR);
    axi(1'b1, REG_STAT_OFF, 32'hffff_ffff, 4'hf, 0, RESP_SLVERR);
    axi(1'b1, REG_MODE_OFF, 32'hffff_ff02, 4'h1, 0, RESP_OKAY);
    axi(1'b0, REG_MODE_OFF, 0, 4'h0, 32'h0000_0f02, RESP_OKAY);
    // A second reset in mid-run restores both registers.
    reset <= 1'b1;
    repeat (3) @(posedge core_clk);
    reset <= 1'b0;
    axi(1'b0, REG_MODE_OFF, 0, 4'h0, MODE_RST, RESP_OKAY);
    axi(1'b0, REG_STAT_OFF, 0, 4'h0, 32'h0, RESP_OKAY);
    final_report();
  end
endmodule
bind ddrb_burst_dev ddrb_burst_dev_sva ddrb_burst_dev_sva_inst (.core_clk, .reset, .link_clk,
  .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .rd_data_oe, .rd_strobe_o,
  .rd_strobe_oe);
